//--- common/tscr_regs.vh
`ifndef TSCR_REGS_VH
`define TSCR_REGS_VH

// Register addresses (7-bit command address)
`define TSCR_ADDR_STATUS    7'h00
`define TSCR_ADDR_CONFIG    7'h01

// Reset values
`define TSCR_STATUS_RST     8'h00
`define TSCR_CONFIG_RST     8'hF0

// Status field positions
`define TSCR_ST_ADC_BUSY    7
`define TSCR_ST_LOW_POWER   6
`define TSCR_ST_DETECT_MODE 5
`define TSCR_ST_SCAN        4
`define TSCR_ST_QUEUE_OVR   3
`define TSCR_ST_QUEUE_NEW   2
`define TSCR_ST_EDGE_EVT    1
`define TSCR_ST_PRESENT     0

// Configuration field positions
`define TSCR_CF_RES_SEL     7
`define TSCR_CF_DOUT_HOLD   6
`define TSCR_CF_PULLUP      5
`define TSCR_CF_OPEN_DRAIN  4
`define TSCR_CF_MASK        3
`define TSCR_CF_EDGE_SEL    2
`define TSCR_CF_EDGE_TIME   1:0

// Edge width codes
`define TSCR_EDGE_4         2'h0
`define TSCR_EDGE_16        2'h1
`define TSCR_EDGE_64        2'h2

// Timing: oscillator period and reference clock period in ns
`define TSCR_OSC_PERIOD_NS  500
`define TSCR_CLK_PERIOD_NS  20
`define TSCR_OSC_DIV        (`TSCR_OSC_PERIOD_NS / `TSCR_CLK_PERIOD_NS)
// Divider terminal count, one below the division ratio
`define TSCR_OSC_LAST       5'h18
`define TSCR_EDGE_N4        7'h04
`define TSCR_EDGE_N16       7'h10
`define TSCR_EDGE_N64       7'h40

// Serial framing
`define TSCR_CMD_BITS       4'h8
`define TSCR_FRAME_BITS     5'h10

`endif

//--- rtl/tscr_spi_slave.v
`timescale 1ns/1ps
`include "tscr_regs.vh"

module tscr_spi_slave (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_b,
   // Serial pins, sampled on clk
   input  wire       cs_b,
   input  wire       sclk,
   input  wire       din,
   output wire       dout,
   output wire       dout_oe,
   // Register side
   output wire [6:0] addr,
   output wire       wr_stb,
   output wire [7:0] wdata,
   input  wire [7:0] rdata
);

   reg        sclk_q;
   reg  [4:0] cnt_q;
   reg  [7:0] sh_q;
   reg  [7:0] cmd_q;
   reg  [7:0] tx_q;
   reg        wr_q;
   reg  [7:0] wdata_q;
   wire       rise;
   wire       fall;
   wire       rd_mode;

   assign rise    = ~cs_b & sclk & ~sclk_q;
   assign fall    = ~cs_b & ~sclk & sclk_q;
   assign rd_mode = cmd_q[0];
   assign addr    = cmd_q[7:1];
   assign wr_stb  = wr_q;
   assign wdata   = wdata_q;
   assign dout    = tx_q[7];
   // Drive only during the data byte of a read
   assign dout_oe = ~cs_b & rd_mode & (cnt_q >= {1'b0, `TSCR_CMD_BITS});

   // Bit counter, shift in on rising edge, shift out on falling edge
   always @(posedge clk) begin
      if (!rst_b) begin
         sclk_q  <= 1'b0;
         cnt_q   <= 5'h00;
         sh_q    <= 8'h00;
         cmd_q   <= 8'h00;
         tx_q    <= 8'h00;
         wr_q    <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         sclk_q <= sclk;
         wr_q   <= 1'b0;
         if (cs_b) begin
            cnt_q <= 5'h00;
         end else begin
            if (rise && cnt_q < `TSCR_FRAME_BITS) begin
               sh_q  <= {sh_q[6:0], din};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'h07)
                  cmd_q <= {sh_q[6:0], din};
               if (cnt_q == 5'h0F && !rd_mode) begin
                  wr_q    <= 1'b1;
                  wdata_q <= {sh_q[6:0], din};
               end
            end
            if (fall && rd_mode) begin
               if (cnt_q == {1'b0, `TSCR_CMD_BITS})
                  tx_q <= rdata;
               else if (cnt_q > {1'b0, `TSCR_CMD_BITS})
                  tx_q <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

endmodule

//--- rtl/tscr_top.v
// Functional notes
// - Edge select picks edge or continuous, direct mode
// - Mask bit holds interrupt output inactive
// - Pullup enabled only with open-drain drive
// - Hold bit enables serial data-out bus holder
`timescale 1ns/1ps
`include "tscr_regs.vh"

module tscr_top (
   // Clock and reset
   input  wire REF_CLK,
   input  wire RST_B,
   // Serial register port
   input  wire CS_B,
   input  wire SCLK,
   input  wire DIN,
   output wire DOUT,
   output wire DOUT_OE,
   output wire DOUT_HOLD_EN,
   // Conditions reported by the rest of the controller
   input  wire ADC_BUSY,
   input  wire LOW_POWER_STATE_FLAG,
   input  wire DETECT_MODE_FLAG,
   input  wire SCAN_ACTIVE,
   input  wire QUEUE_OVERFLOW_FLAG,
   input  wire QUEUE_NEW_DATA,
   input  wire AUTO_MODE,
   input  wire TOUCH_START,
   input  wire TOUCH_PRESENT,
   // Interrupt pin, active low
   output wire TOUCH_IRQ_OUTPUT_B,
   output wire TOUCH_IRQ_OE,
   output wire IRQ_PULLUP_ENABLE,
   // Panel control
   output wire DETECT_RESISTOR_SELECT
);

   wire [6:0] addr;
   wire       wr_stb;
   wire [7:0] wdata;
   reg  [7:0] rdata;
   reg  [7:0] status;
   reg  [7:0] cfg_q;
   reg  [4:0] div_q;
   reg        tick_q;
   reg  [6:0] pulse_q;
   reg        irq_q;
   reg        irq_oe_q;
   reg        pull_q;
   reg        irq_req;
   reg        edge_busy;
   reg        cont_flag;
   wire [1:0] style;
   wire       edge_mode;
   wire [1:0] drive;
   wire       od;

   // Interrupt source styles
   localparam [1:0] STYLE_CONT = 2'h0;
   localparam [1:0] STYLE_EDGE = 2'h1;
   localparam [1:0] STYLE_AUTO = 2'h2;

   // Edge width decode, reserved code taken as the longest width
   function [6:0] edge_len;
      input [1:0] code;
      begin
         case (code)
            `TSCR_EDGE_4:  edge_len = `TSCR_EDGE_N4;
            `TSCR_EDGE_16: edge_len = `TSCR_EDGE_N16;
            `TSCR_EDGE_64: edge_len = `TSCR_EDGE_N64;
            default:       edge_len = `TSCR_EDGE_N64;
         endcase
      end
   endfunction

   // Interrupt style, edge style exists only in direct mode
   function [1:0] irq_style;
      input auto_md;
      input edge_sel;
      begin
         if (auto_md)
            irq_style = STYLE_AUTO;
         else if (edge_sel)
            irq_style = STYLE_EDGE;
         else
            irq_style = STYLE_CONT;
      end
   endfunction

   // Pin drive as {value, enable}; a masked pin stays inactive
   function [1:0] pin_drive;
      input mask;
      input open_drain;
      input req;
      begin
         case ({mask, open_drain})
            2'h0:    pin_drive = {~req, 1'b1};
            2'h1:    pin_drive = {1'b0, req};
            2'h2:    pin_drive = 2'h3;
            2'h3:    pin_drive = 2'h2;
            default: pin_drive = 2'h2;
         endcase
      end
   endfunction

   tscr_spi_slave u_spi (
      .clk     (REF_CLK),
      .rst_b   (RST_B),
      .cs_b    (CS_B),
      .sclk    (SCLK),
      .din     (DIN),
      .dout    (DOUT),
      .dout_oe (DOUT_OE),
      .addr    (addr),
      .wr_stb  (wr_stb),
      .wdata   (wdata),
      .rdata   (rdata)
   );

   // Interrupt style selection
   assign style     = irq_style(AUTO_MODE, cfg_q[`TSCR_CF_EDGE_SEL]);
   assign edge_mode = (style == STYLE_EDGE);

   // Interrupt request and event flags per style
   always @* begin
      irq_req   = 1'b0;
      edge_busy = 1'b0;
      cont_flag = 1'b0;
      case (style)
         STYLE_CONT: begin
            irq_req   = TOUCH_PRESENT;
            cont_flag = TOUCH_PRESENT;
         end
         STYLE_EDGE: begin
            irq_req   = (pulse_q != 7'h00);
            edge_busy = (pulse_q != 7'h00);
         end
         STYLE_AUTO: begin
            irq_req   = QUEUE_NEW_DATA;
         end
         default: begin
            irq_req   = 1'b0;
         end
      endcase
   end

   // Status assembly, queue flags only in autonomous mode
   always @* begin
      status                       = `TSCR_STATUS_RST;
      status[`TSCR_ST_ADC_BUSY]    = ADC_BUSY;
      status[`TSCR_ST_LOW_POWER]   = LOW_POWER_STATE_FLAG;
      status[`TSCR_ST_DETECT_MODE] = DETECT_MODE_FLAG;
      status[`TSCR_ST_SCAN]        = SCAN_ACTIVE;
      status[`TSCR_ST_QUEUE_OVR]   = QUEUE_OVERFLOW_FLAG & AUTO_MODE;
      status[`TSCR_ST_QUEUE_NEW]   = QUEUE_NEW_DATA & AUTO_MODE;
      status[`TSCR_ST_EDGE_EVT]    = edge_busy;
      status[`TSCR_ST_PRESENT]     = cont_flag;
   end

   // Read data mux, unmapped addresses read zero
   always @* begin
      case (addr)
         `TSCR_ADDR_STATUS: rdata = status;
         `TSCR_ADDR_CONFIG: rdata = cfg_q;
         default:           rdata = 8'h00;
      endcase
   end

   // Configuration register, status writes ignored
   always @(posedge REF_CLK) begin
      if (!RST_B)
         cfg_q <= `TSCR_CONFIG_RST;
      else if (wr_stb && addr == `TSCR_ADDR_CONFIG)
         cfg_q <= wdata;
   end

   // Oscillator period tick from the reference clock
   always @(posedge REF_CLK) begin
      if (!RST_B) begin
         div_q  <= 5'h00;
         tick_q <= 1'b0;
      end else if (div_q == `TSCR_OSC_LAST) begin
         div_q  <= 5'h00;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 5'h01;
         tick_q <= 1'b0;
      end
   end

   // Edge pulse width counter in oscillator periods
   always @(posedge REF_CLK) begin
      if (!RST_B)
         pulse_q <= 7'h00;
      else if (edge_mode && TOUCH_START)
         pulse_q <= edge_len(cfg_q[`TSCR_CF_EDGE_TIME]);
      else if (!edge_mode)
         pulse_q <= 7'h00;
      else if (tick_q && pulse_q != 7'h00)
         pulse_q <= pulse_q - 7'h01;
   end

   // Pin flops; pullup follows the open-drain bit so it never meets a high drive
   assign od    = cfg_q[`TSCR_CF_OPEN_DRAIN];
   assign drive = pin_drive(cfg_q[`TSCR_CF_MASK], od, irq_req);
   always @(posedge REF_CLK) begin
      if (!RST_B) begin
         irq_q    <= 1'b1;
         irq_oe_q <= 1'b0;
         pull_q   <= 1'b1;
      end else begin
         irq_q    <= drive[1];
         irq_oe_q <= drive[0];
         pull_q   <= cfg_q[`TSCR_CF_PULLUP] & od;
      end
   end

   assign TOUCH_IRQ_OUTPUT_B     = irq_q;
   assign TOUCH_IRQ_OE           = irq_oe_q;
   assign IRQ_PULLUP_ENABLE      = pull_q;
   assign DOUT_HOLD_EN           = cfg_q[`TSCR_CF_DOUT_HOLD];
   assign DETECT_RESISTOR_SELECT = cfg_q[`TSCR_CF_RES_SEL];

endmodule

//--- bench/tscr_monitor.sv
`timescale 1ns/1ps
module tscr_monitor (
   // Watched top ports
   input wire REF_CLK,
   input wire RST_B,
   input wire CS_B,
   input wire DOUT_OE,
   input wire DOUT_HOLD_EN,
   input wire AUTO_MODE,
   input wire TOUCH_START,
   input wire TOUCH_PRESENT,
   input wire TOUCH_IRQ_OUTPUT_B,
   input wire TOUCH_IRQ_OE,
   input wire IRQ_PULLUP_ENABLE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // Pin pulled low by the device
   wire act = TOUCH_IRQ_OE && !TOUCH_IRQ_OUTPUT_B;
   logic [11:0] run_q;
   // Low cycles with no level source behind them
   always @(posedge REF_CLK) begin
      if (!RST_B || !act || TOUCH_START || TOUCH_PRESENT || AUTO_MODE)
         run_q <= 12'h000;
      else
         run_q <= run_q + 12'h001;
   end
   property p_src;
      $rose(act) && !AUTO_MODE |->
         $past(TOUCH_PRESENT) || $past(TOUCH_START, 2);
   endproperty
   a_src: assert property (p_src)
      else $error("irq rose without cause");
   property p_min;
      $rose(act) && !AUTO_MODE && !$past(TOUCH_PRESENT) |-> act[*8];
   endproperty
   a_min: assert property (p_min)
      else $error("edge pulse too short");
   property p_width;
      run_q <= 12'h65A;
   endproperty
   a_width: assert property (p_width)
      else $error("edge pulse too long");
   property p_pull;
      IRQ_PULLUP_ENABLE |-> !(TOUCH_IRQ_OE && TOUCH_IRQ_OUTPUT_B);
   endproperty
   a_pull: assert property (p_pull)
      else $error("pullup on while driven high");
   property p_hold;
      $changed(DOUT_HOLD_EN) |-> !$past(CS_B, 2);
   endproperty
   a_hold: assert property (p_hold)
      else $error("holder changed outside a frame");
   property p_oe;
      DOUT_OE |-> !CS_B && !$past(CS_B, 16);
   endproperty
   a_oe: assert property (p_oe)
      else $error("data out driven before the data byte");
endmodule

//--- bench/tscr_host.sv
`timescale 1ns/1ps
module tscr_host (
   // Clock and serial pins
   input  wire  clk,
   input  wire  dout,
   output logic cs_b,
   output logic sclk,
   output logic din
);
   // One frame, mode 0, MSB first, three clocks a half period
   task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
      integer i;
      rx = 8'h00;
      cs_b = 1'b0;
      for (i = 15; i >= 0; i--) begin
         din = tx[i];
         repeat (3) @(negedge clk);
         sclk = 1'b1;
         if (i < 8)
            rx = {rx[6:0], dout};
         repeat (3) @(negedge clk);
         sclk = 1'b0;
      end
      // Select held until a write lands; data line then inverted
      repeat (2) @(negedge clk);
      cs_b = 1'b1;
      din = ~din;
      repeat (3) @(negedge clk);
   endtask
   // Idle pins
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
endmodule

//--- bench/touch_status_config_regs_tb.sv
`timescale 1ns/1ps
module touch_status_config_regs_tb;
   logic        clk, rst_b, t_st, t_pr, auto_md;
   logic [5:0]  st;
   logic [7:0]  rd;
   wire         cs_b, sclk, din, dout, hold, irq_b, irq_oe, pull, rsel;
   integer      errors = 0, checks_done = 0, i, w;
   // Config, touch level, {pullup, holder, resistor, oe, irq_b}
   logic [13:0] rows [7] = '{{8'hF0,1'b0,5'h1C}, {8'h20,1'b0,5'h03},
      {8'h70,1'b1,5'h1A}, {8'hC4,1'b1,5'h0F}, {8'h08,1'b1,5'h03},
      {8'h38,1'b1,5'h11}, {8'h00,1'b1,5'h02}};
   tscr_host host_u (.clk(clk), .dout(dout), .cs_b(cs_b), .sclk(sclk),
      .din(din));
   tscr_top dut_u (.REF_CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk),
      .DIN(din), .DOUT(dout), .DOUT_OE(), .DOUT_HOLD_EN(hold),
      .ADC_BUSY(st[5]), .LOW_POWER_STATE_FLAG(st[4]),
      .DETECT_MODE_FLAG(st[3]), .SCAN_ACTIVE(st[2]),
      .QUEUE_OVERFLOW_FLAG(st[1]), .QUEUE_NEW_DATA(st[0]),
      .AUTO_MODE(auto_md), .TOUCH_START(t_st), .TOUCH_PRESENT(t_pr),
      .TOUCH_IRQ_OUTPUT_B(irq_b), .TOUCH_IRQ_OE(irq_oe),
      .IRQ_PULLUP_ENABLE(pull), .DETECT_RESISTOR_SELECT(rsel));
   task automatic cmp(input string nm, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic [6:0] a, input logic r,
      input logic [7:0] v);
      host_u.frame({a, r, v}, rd);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard
   initial begin
      #1000000;
      errors++;
      end_sim;
   end
   initial begin
      {rst_b, t_st, t_pr, auto_md, st} = 10'h000;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      for (i = 0; i < 7; i++) begin
         t_pr = rows[i][5];
         xfer(7'h01, 1'b0, rows[i][13:6]);
         xfer(7'h01, 1'b1, 8'h00);
         cmp("config", rows[i][13:6], rd);
         cmp("pins", rows[i][4:0], {pull, hold, rsel, irq_oe, irq_b});
      end
      $display("row tests done");
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      {rst_b, t_pr, auto_md, st} = 9'h17F;
      xfer(7'h01, 1'b1, 8'h00);
      cmp("config reset", 8'hF0, rd);
      xfer(7'h00, 1'b0, 8'hFF);
      xfer(7'h00, 1'b1, 8'h00);
      cmp("status", 8'hFC, rd);
      xfer(7'h05, 1'b1, 8'h00);
      cmp("unmapped", 8'h00, rd);
      {auto_md, st} = 7'h00;
      $display("reset and status tests done");
      for (i = 0; i < 3; i++) begin
         xfer(7'h01, 1'b0, 8'h04 | i[7:0]);
         t_st = 1'b1;
         @(negedge clk);
         t_st = 1'b0;
         w = 0;
         repeat (1700) begin
            @(negedge clk);
            if (irq_oe === 1'b1 && irq_b === 1'b0)
               w++;
         end
         cmp("edge width", 16'h0001,
            w > (4 << 2 * i) * 25 - 25 && w <= (4 << 2 * i) * 25);
      end
      $display("edge tests done");
      t_pr = 1'b1;
      t_st = 1'b1;
      @(negedge clk);
      t_st = 1'b0;
      xfer(7'h00, 1'b1, 8'h00);
      cmp("edge status", 8'h02, rd);
      xfer(7'h01, 1'b0, 8'h00);
      xfer(7'h00, 1'b1, 8'h00);
      cmp("cont status", 8'h01, rd);
      $display("status flag tests done");
      end_sim;
   end
endmodule
bind tscr_top tscr_monitor mon_u (.REF_CLK(REF_CLK), .RST_B(RST_B),
   .CS_B(CS_B), .DOUT_OE(DOUT_OE), .DOUT_HOLD_EN(DOUT_HOLD_EN),
   .AUTO_MODE(AUTO_MODE),
   .TOUCH_START(TOUCH_START), .TOUCH_PRESENT(TOUCH_PRESENT),
   .TOUCH_IRQ_OUTPUT_B(TOUCH_IRQ_OUTPUT_B), .TOUCH_IRQ_OE(TOUCH_IRQ_OE),
   .IRQ_PULLUP_ENABLE(IRQ_PULLUP_ENABLE));
